// *** aesc_regs.vh ***
/*
  Register map, field positions, reset values and codes of the cipher
  coprocessor control block. Definitions only; included by bare name.
*/
`ifndef AESC_REGS_VH
`define AESC_REGS_VH

// Register offsets on the byte-wide register port
`define AESC_ADDR_INPUT 8'hb1
`define AESC_ADDR_OUTPUT 8'hb2
`define AESC_ADDR_CTRL 8'hb3
`define AESC_ADDR_IRQ_STATUS 8'hb4
`define AESC_ADDR_IRQ_CLEAR 8'hb5
`define AESC_ADDR_IRQ_ENABLE 8'hb6

// Control/status field positions
`define AESC_CS_START_BIT 0
`define AESC_CS_CMD_LSB 1
`define AESC_CS_CMD_MSB 2
`define AESC_CS_READY_BIT 3
`define AESC_CS_MODE_LSB 4
`define AESC_CS_MODE_MSB 6
`define AESC_CS_UNUSED_BIT 7

// Interrupt status/enable/clear layout
`define AESC_IRQ_DONE_BIT 0

// Reset values
`define AESC_RST_DATA 8'h00
`define AESC_RST_MODE 3'h0
`define AESC_RST_CMD 2'h0
`define AESC_RST_READY 1'b1
`define AESC_RST_IRQ 1'b0

// Chaining mode codes
`define AESC_MODE_CBC 3'h0
`define AESC_MODE_CFB 3'h1
`define AESC_MODE_OFB 3'h2
`define AESC_MODE_CTR 3'h3
`define AESC_MODE_ECB 3'h4
`define AESC_MODE_CBCMAC 3'h5

// Command codes
`define AESC_CMD_ENCRYPT 2'h0
`define AESC_CMD_DECRYPT 2'h1
`define AESC_CMD_LOAD_KEY 2'h2
`define AESC_CMD_LOAD_IV 2'h3

// Bytes in one 128-bit block, and core latency in cycles
`define AESC_BLOCK_BYTES 5'h10
`define AESC_CORE_CYCLES 8

`endif

// *** aesc_core.v ***
/*
  Stand-in block transform of the cipher coprocessor: a keyed, invertible
  permutation over a fixed number of cycles. It keeps the timing of a
  real round engine so the control logic around it can be exercised.
  Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/1ns
`default_nettype none

`include "aesc_regs.vh"

module aesc_core #(
  parameter CYCLES = `AESC_CORE_CYCLES
) (
  input wire clk_sys,
  input wire rst_n,
  input wire start,
  input wire decrypt,
  input wire [127:0] key,
  input wire [127:0] din,
  output wire busy,
  output reg done,
  output reg [127:0] dout
);

  reg [7:0] cnt_r;
  reg dec_r;
  reg [127:0] hold_r;

  // Count the rounds down, then present the transformed block
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      dec_r <= 1'b0;
      hold_r <= 128'h0;
      done <= 1'b0;
      dout <= 128'h0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= CYCLES[7:0];
        dec_r <= decrypt;
        hold_r <= din;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          done <= 1'b1;
          // Inverse pair: xor then rotate, or rotate back then xor
          if (dec_r)
            dout <= {hold_r[7:0], hold_r[127:8]} ^ key;
          else
            dout <= {hold_r[119:0], hold_r[127:120]} ^ {key[119:0], key[127:120]};
        end
      end
    end
  end

  assign busy = (cnt_r != 8'h00);

endmodule // aesc_core

`default_nettype wire

// *** aesc_top.v ***
/*
  Control and data interface of the block-cipher coprocessor: byte-wide
  register port, 16-byte input and output block buffers, chaining modes,
  key and IV storage, download/upload DMA triggers and completion interrupt.
  Assumes a register master on clk_sys with one-cycle strobes, never both
  at once, and a single owner driving the block at any time.
*/
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none

`include "aesc_regs.vh"

module aesc_top #(
  parameter CORE_CYCLES = `AESC_CORE_CYCLES
) (
  input wire clk_sys,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output wire cipher_done_irq,
  output wire cipher_dma_download_trigger,
  output wire cipher_dma_upload_trigger
);

  // One-hot sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_LOAD = 3'b010;
  localparam ST_RUN = 3'b100;

  // Modes whose core input is the chaining value, not the data
  function stream_mode;
    input [2:0] m;
    begin
      stream_mode = (m == `AESC_MODE_CFB) || (m == `AESC_MODE_OFB) ||
                    (m == `AESC_MODE_CTR);
    end
  endfunction

  // Modes that chain through the previous cipher block
  function cbc_mode;
    input [2:0] m;
    begin
      cbc_mode = (m == `AESC_MODE_CBC) || (m == `AESC_MODE_CBCMAC);
    end
  endfunction

  // Reset copy, control fields, operation latches and block buffers
  reg rst_meta_r;
  reg rst_n;
  reg [2:0] state_r;
  reg [2:0] mode_r;
  reg [1:0] cmd_r;
  reg [1:0] op_cmd_r;
  reg [2:0] op_mode_r;
  reg start_r;
  reg ready_r;
  reg [127:0] in_buf_r;
  reg [7:0] in_last_r;
  reg [4:0] in_cnt_r;
  reg [127:0] out_buf_r;
  reg [4:0] out_cnt_r;
  reg [127:0] key_r;
  reg [127:0] iv_r;
  reg irq_flag_r;
  reg irq_en_r;
  reg core_start_r;
  reg [127:0] core_in_r;
  reg [127:0] result;
  reg [127:0] iv_nxt;

  // Decoded strobes and status of the sequencer
  wire core_busy;
  wire core_done;
  wire [127:0] core_out;
  wire wr_input;
  wire wr_output;
  wire wr_ctrl;
  wire rd_output;
  wire start_ok;
  wire block_full;
  wire op_dec;
  wire wr_irq_clear;
  wire wr_irq_enable;

  // Reset enters asynchronously and is released through two flops,
  // so no flop sees the release edge close to a clock edge
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Register port address decode
  assign wr_input = reg_wr && (reg_addr == `AESC_ADDR_INPUT);
  assign wr_output = reg_wr && (reg_addr == `AESC_ADDR_OUTPUT);
  assign wr_ctrl = reg_wr && (reg_addr == `AESC_ADDR_CTRL);
  assign rd_output = reg_rd && (reg_addr == `AESC_ADDR_OUTPUT);
  assign wr_irq_clear = reg_wr && (reg_addr == `AESC_ADDR_IRQ_CLEAR);
  assign wr_irq_enable = reg_wr && (reg_addr == `AESC_ADDR_IRQ_ENABLE);
  assign start_ok = wr_ctrl && reg_wdata[`AESC_CS_START_BIT] && (state_r == ST_IDLE);
  // Sixteen bytes make one block
  assign block_full = (in_cnt_r == `AESC_BLOCK_BYTES);
  // Decrypt as latched at start
  assign op_dec = (op_cmd_r == `AESC_CMD_DECRYPT);

  assign cipher_dma_download_trigger = (state_r == ST_LOAD) && !block_full;
  assign cipher_dma_upload_trigger = (out_cnt_r != `AESC_BLOCK_BYTES);
  assign cipher_done_irq = irq_flag_r && irq_en_r;

  // Stream modes always run the forward transform, even to decrypt
  aesc_core #(
    .CYCLES(CORE_CYCLES)
  ) u_core (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(core_start_r),
    .decrypt(op_dec && !stream_mode(op_mode_r)),
    .key(key_r),
    .din(core_in_r),
    .busy(core_busy),
    .done(core_done),
    .dout(core_out)
  );

  // Finish the chaining around the core output and pick the next IV
  always @* begin
    // Defaults: ECB passes the core output through and keeps the IV
    result = core_out;
    iv_nxt = iv_r;
    if (stream_mode(op_mode_r)) begin
      result = core_out ^ in_buf_r;
      case (op_mode_r)
        `AESC_MODE_CFB: iv_nxt = op_dec ? in_buf_r : result;
        `AESC_MODE_OFB: iv_nxt = core_out;
        // Counter steps in its low 32 bits only, wrapping there
        default: iv_nxt = {iv_r[127:32], iv_r[31:0] + 32'h00000001};
      endcase
    end else if (cbc_mode(op_mode_r)) begin
      // Decrypt unchains after the core; MAC steps chain like CBC encrypt
      if (op_dec) begin
        result = core_out ^ iv_r;
        iv_nxt = in_buf_r;
      end else begin
        iv_nxt = core_out;
      end
    end
  end

  // Control/status fields; mode may change between blocks for CBC-MAC
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `AESC_RST_MODE;
      cmd_r <= `AESC_RST_CMD;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (wr_ctrl) begin
        // Fields take every control write, even a start refused as busy
        // mode field
        mode_r <= reg_wdata[`AESC_CS_MODE_MSB:`AESC_CS_MODE_LSB];
        cmd_r <= reg_wdata[`AESC_CS_CMD_MSB:`AESC_CS_CMD_LSB];
        start_r <= reg_wdata[`AESC_CS_START_BIT];
      end
    end
  end

  // Operation sequencer: collect a block, run the core, deliver results
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      ready_r <= `AESC_RST_READY;
      op_cmd_r <= `AESC_RST_CMD;
      op_mode_r <= `AESC_RST_MODE;
      in_cnt_r <= 5'h00;
      // Key and IV clear to zero; software reloads them after any reset
      key_r <= 128'h0;
      iv_r <= 128'h0;
      core_start_r <= 1'b0;
      core_in_r <= 128'h0;
    end else begin
      core_start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_ok) begin
            // ready falls at start; mode and command taken together
            ready_r <= 1'b0;
            op_cmd_r <= reg_wdata[`AESC_CS_CMD_MSB:`AESC_CS_CMD_LSB];
            op_mode_r <= reg_wdata[`AESC_CS_MODE_MSB:`AESC_CS_MODE_LSB];
            in_cnt_r <= 5'h00;
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (wr_input && !block_full)
            in_cnt_r <= in_cnt_r + 5'h01;
          if (block_full) begin
            case (op_cmd_r)
              // Key and IV loads finish without the core
              `AESC_CMD_LOAD_KEY: begin
                key_r <= in_buf_r;
                ready_r <= 1'b1;
                state_r <= ST_IDLE;
              end
              `AESC_CMD_LOAD_IV: begin
                iv_r <= in_buf_r;
                ready_r <= 1'b1;
                state_r <= ST_IDLE;
              end
              default: begin
                // The core is idle here; the guard keeps a stray restart out
                if (!core_busy) begin
                  core_start_r <= 1'b1;
                  // Stream modes feed the chaining value, CBC encrypt folds the IV in
                  if (stream_mode(op_mode_r))
                    core_in_r <= iv_r;
                  else if (cbc_mode(op_mode_r) && !op_dec)
                    core_in_r <= in_buf_r ^ iv_r;
                  else
                    core_in_r <= in_buf_r;
                  state_r <= ST_RUN;
                end
              end
            endcase
          end
        end
        ST_RUN: begin
          if (core_done) begin
            ready_r <= 1'b1;
            iv_r <= iv_nxt;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          // An illegal state code falls back to idle and reports ready
          state_r <= ST_IDLE;
          ready_r <= 1'b1;
        end
      endcase
    end
  end

  // Input byte register: bytes shift in first-byte-most-significant
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_buf_r <= 128'h0;
      in_last_r <= `AESC_RST_DATA;
    end else if (wr_input) begin
      // Outside a load only the readback byte takes the write
      in_last_r <= reg_wdata;
      if (state_r == ST_LOAD && !block_full)
        in_buf_r <= {in_buf_r[119:0], reg_wdata};
    end
  end

  // Output buffer; a CBC-MAC step keeps its result internal, nothing to upload
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_buf_r <= 128'h0;
      out_cnt_r <= `AESC_BLOCK_BYTES;
    end else if (state_r == ST_RUN && core_done) begin
      out_buf_r <= result;
      if (op_mode_r == `AESC_MODE_CBCMAC)
        out_cnt_r <= `AESC_BLOCK_BYTES;
      else
        out_cnt_r <= 5'h00;
    end else if (rd_output && out_cnt_r != `AESC_BLOCK_BYTES) begin
      out_buf_r <= {out_buf_r[119:0], out_buf_r[127:120]};
      out_cnt_r <= out_cnt_r + 5'h01;
    end else if (wr_output) begin
      // A host write replaces the byte at the head of the result queue
      out_buf_r[127:120] <= reg_wdata;
    end
  end

  // Sticky completion flag: a completion in the clear cycle wins
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_r <= `AESC_RST_IRQ;
      irq_en_r <= `AESC_RST_IRQ;
    end else begin
      if (state_r == ST_RUN && core_done)
        irq_flag_r <= 1'b1;
      else if (wr_irq_clear && reg_wdata[`AESC_IRQ_DONE_BIT])
        irq_flag_r <= 1'b0;
      // Disabling hides the flag at the output but keeps it for polling
      if (wr_irq_enable)
        irq_en_r <= reg_wdata[`AESC_IRQ_DONE_BIT];
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `AESC_ADDR_INPUT: reg_rdata <= in_last_r;
        `AESC_ADDR_OUTPUT: reg_rdata <= out_buf_r[127:120];
        `AESC_ADDR_CTRL: reg_rdata <= {1'b0, mode_r, ready_r, cmd_r, start_r};
        `AESC_ADDR_IRQ_STATUS: reg_rdata <= {7'h00, irq_flag_r};
        `AESC_ADDR_IRQ_ENABLE: reg_rdata <= {7'h00, irq_en_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      // Zero between reads, so the data stands for exactly one cycle
      reg_rdata <= 8'h00;
    end
  end

endmodule // aesc_top

`default_nettype wire

// *** aesc_top_asserts.sv ***
/* Port-level checks of the cipher coprocessor control block.
   Assumes it is bound onto aesc_top and sees only that module's ports. */
`timescale 1ns/1ns
`default_nettype none
module aesc_top_asserts #(
  parameter CORE_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cipher_done_irq,
  input wire logic cipher_dma_download_trigger,
  input wire logic cipher_dma_upload_trigger
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // Control write with the start bit set
  sequence s_start;
    reg_wr && reg_addr == 8'hb3 && reg_wdata[0];
  endsequence
  // Cycles since the last input byte; saturates so it never wraps
  int wait_r;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      wait_r <= 1000;
    else if ($fell(cipher_dma_download_trigger))
      wait_r <= 0;
    else if (wait_r < 1000)
      wait_r <= wait_r + 1;
  end
  AST_BIT7_ZERO: assert property (reg_rd && reg_addr == 8'hb3 |=> !reg_rdata[7])
    else $error("control bit 7 read as one");
  AST_DW_ON: assert property (s_start |=> cipher_dma_download_trigger)
    else $error("download trigger missing after start");
  AST_DW_RISE: assert property ($rose(cipher_dma_download_trigger) |->
    $past(reg_wr && reg_addr == 8'hb3 && reg_wdata[0])) else $error("download without start");
  AST_DW_FALL: assert property ($fell(cipher_dma_download_trigger) |->
    $past(reg_wr && reg_addr == 8'hb1)) else $error("download ended without input write");
  AST_UP_HOLD: assert property (cipher_dma_upload_trigger && !reg_rd |=>
    cipher_dma_upload_trigger) else $error("upload trigger dropped without read");
  AST_UP_FALL: assert property ($fell(cipher_dma_upload_trigger) |->
    $past(reg_rd && reg_addr == 8'hb2)) else $error("upload ended without output read");
  AST_IRQ_WITH_UP: assert property ($rose(cipher_done_irq) && !$past(reg_wr) |->
    $rose(cipher_dma_upload_trigger)) else $error("interrupt without result");
  AST_IRQ_MASK: assert property (reg_wr && reg_addr == 8'hb6 && !reg_wdata[0] |=>
    !cipher_done_irq) else $error("interrupt while disabled");
  AST_CORE_TIME: assert property (wait_r < CORE_CYCLES |->
    !$rose(cipher_dma_upload_trigger)) else $error("result before core time");
endmodule // aesc_top_asserts
`default_nettype wire

// *** aesc_host_model.sv ***
/* Host side of the register port: processor core or DMA channel.
   Assumes each task is entered right after a rising clock edge. */
`timescale 1ns/1ns
`default_nettype none
module aesc_host_model (
  input wire logic clk_sys,
  output var logic [7:0] reg_addr,
  output var logic [7:0] reg_wdata,
  output var logic reg_wr,
  output var logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // sole owner of the port
  // Idle data toggles so a stale byte is never mistaken for a fresh one
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= w ? d : ~reg_wdata;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    cyc(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle();
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic blk_in(input logic [127:0] b);
    for (int i = 0; i < 16; i++)
      wr(8'hb1, b[127-8*i -: 8]);
  endtask
endmodule // aesc_host_model
`default_nettype wire

// *** aes_coprocessor_control_bench.sv ***
/* Self-checking bench of the cipher coprocessor control block.
   Assumes aesc_top, the host model and the port checker. */
`timescale 1ns/1ns
`default_nettype none
module aes_coprocessor_control_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, irq, dw, up;
  int error_cnt = 0;
  int total_checks = 0;
  logic [8:0] exp_q[$];
  logic [7:0] cap_q[$];
  logic rd_q = 1'b0;
  logic [127:0] pt;
  logic [127:0] ct;
  logic [127:0] key_v;
  logic [127:0] iv_v;
  aesc_top #(.CORE_CYCLES(8)) uut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cipher_done_irq(irq),
    .cipher_dma_download_trigger(dw),
    .cipher_dma_upload_trigger(up)
  );
  aesc_host_model host (
    .clk_sys(clk_sys),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd)
  );
  always #10 clk_sys = ~clk_sys;
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Forward model of the stand-in core: xor the key, then rotate left a byte
  function automatic logic [127:0] enc_m(input logic [127:0] x, input logic [127:0] k);
    logic [127:0] t;
    t = x ^ k;
    return {t[119:0], t[127:120]};
  endfunction
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({1'b1, e});
    host.rd(a);
  endtask
  // Read data stand one cycle after the strobe; oldest note is taken
  always @(posedge clk_sys) begin
    if (rd_q && exp_q.size() > 0) begin
      if (exp_q[0][8])
        cmp8("reg_rdata", exp_q[0][7:0], reg_rdata);
      else
        cap_q.push_back(reg_rdata);
      void'(exp_q.pop_front());
    end
    rd_q <= reg_rd;
  end
  // Start a command, feed its block, then let it finish
  task automatic run(input logic [7:0] cs, input logic [127:0] b);
    host.wr(8'hb3, cs);
    chk_rd(8'hb3, cs & 8'h77);
    cmp8("download", 8'h01, {7'h0, dw});
    host.blk_in(b);
    host.idle();
    cmp8("download", 8'h00, {7'h0, dw});
    repeat (14) host.idle();
    chk_rd(8'hb3, cs & 8'h76 | 8'h08);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length
  initial begin
    #40000;
    error_cnt++;
    final_report;
  end
  initial begin
    void'($urandom(32'h9dca));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) host.idle();
    chk_rd(8'hb3, 8'h08);
    chk_rd(8'hb6, 8'h00);
    chk_rd(8'hb7, 8'h00);
    chk_rd(8'hb2, 8'h00);
    for (int m = 0; m < 8; m++) begin
      host.wr(8'hb3, {1'b1, m[2:0], 1'b0, 2'b01, 1'b0});
      chk_rd(8'hb3, {1'b0, m[2:0], 1'b1, 2'b01, 1'b0});
    end
    key_v = {$urandom, $urandom, $urandom, $urandom};
    run(8'h45, key_v);
    // IV loaded with CFB set in the same write
    iv_v = {$urandom, $urandom, $urandom, $urandom};
    run(8'h17, iv_v);
    host.wr(8'hb6, 8'h01);
    pt = {$urandom, $urandom, $urandom, $urandom};
    run(8'h41, pt);
    cmp8("irq", 8'h01, {7'h0, irq});
    cmp8("upload", 8'h01, {7'h0, up});
    chk_rd(8'hb4, 8'h01);
    host.wr(8'hb5, 8'h01);
    host.idle();
    cmp8("irq", 8'h00, {7'h0, irq});
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back(9'h000);
      host.rd(8'hb2);
    end
    repeat (2) host.idle();
    cmp8("upload", 8'h00, {7'h0, up});
    for (int i = 0; i < 16; i++)
      ct = {ct[119:0], cap_q.pop_front()};
    for (int i = 0; i < 16; i++)
      cmp8("ciphertext", 8'(enc_m(pt, key_v) >> (120 - 8 * i)), ct[127-8*i -: 8]);
    host.wr(8'hb6, 8'h00);
    run(8'h43, ct);
    cmp8("irq", 8'h00, {7'h0, irq});
    chk_rd(8'hb4, 8'h01);
    host.wr(8'hb6, 8'h01);
    host.idle();
    cmp8("irq", 8'h01, {7'h0, irq});
    host.wr(8'hb5, 8'h01);
    for (int i = 0; i < 16; i++)
      chk_rd(8'hb2, pt[127-8*i -: 8]);
    repeat (2) host.idle();
    cmp8("upload", 8'h00, {7'h0, up});
    // MAC chain: a CBC-MAC step keeps its result, CBC on the last block uploads it
    host.wr(8'hb6, 8'h00);
    pt = {$urandom, $urandom, $urandom, $urandom};
    ct = {$urandom, $urandom, $urandom, $urandom};
    run(8'h51, pt);
    cmp8("upload", 8'h00, {7'h0, up});
    cmp8("irq", 8'h00, {7'h0, irq});
    chk_rd(8'hb4, 8'h01);
    run(8'h01, ct);
    ct = enc_m(ct ^ enc_m(pt ^ iv_v, key_v), key_v);
    for (int i = 0; i < 16; i++)
      chk_rd(8'hb2, ct[127-8*i -: 8]);
    repeat (2) host.idle();
    cmp8("upload", 8'h00, {7'h0, up});
    final_report;
  end
endmodule // aes_coprocessor_control_bench
bind aesc_top aesc_top_asserts #(.CORE_CYCLES(CORE_CYCLES)) chk (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .cipher_done_irq(cipher_done_irq),
  .cipher_dma_download_trigger(cipher_dma_download_trigger),
  .cipher_dma_upload_trigger(cipher_dma_upload_trigger)
);
`default_nettype wire
